// ### smi_top.sv
// Operating mode tracking, drive gating and status LEDs of a servo controller
// Assumes an AHB-Lite master on one clock, network status from the fieldbus
// core and calibration sequencing from the position loop
// Contract
// RL1 - Network LED off when offline, flashing green when online without connection.
// RL2 - Network LED steady green when online and allocated to a master.
// RL3 - Network LED flashing red when any connection has timed out.
// RL4 - Network LED steady red when unable to communicate.
// RL5 - Module LED flashing green while configuration or calibration is needed.
// RL6 - Module LED steady green while running normally without fault.
// RL7 - Module LED steady red on internal fault.
// RL8 - Unconfigured: no position control, drive current zero.
// RL9 - Configured but uncalibrated: no position control, drive current zero.
// RL10 - Configured idle: no position control, drive current zero.
// RL11 - Calibrating drives fixed currents, closes loop during verification.
// RL12 - Calibrating and calibrated states ignore normal demand inputs.
// RL13 - Manual stroking regulates to user demand, ignores normal demand.
// RL14 - Running regulates using only the normal demand inputs.
// RL15 - All service-monitored quantities also readable by fieldbus.
// RL16 - Fieldbus gain writes accepted only when configuration enables them.
// RL17 - Fieldbus calibration allowed only when configuration enables it.
// RL18 - Edited configuration has no effect until loaded.
// RL19 - No actuator positioning until a valid configuration is loaded.
// RL20 - Mode changes only from service link, or fieldbus if enabled.
// RL21 - Loading a configuration leaves run and enters configure state.
// RL22 - LED flashing toggles near one hertz from the system clock.
`timescale 1ns/1ns
module smi_top #(
   parameter int unsigned DW             = 16,
   parameter int unsigned CW             = 16,
   parameter int unsigned FLASH_HALF_CYC = smi_pkg::FLASH_HALF_CYC
)(
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_hsel,
   input  wire logic [31:0]         i_haddr,
   input  wire logic [1:0]          i_htrans,
   input  wire logic                i_hwrite,
   input  wire logic [2:0]          i_hsize,
   input  wire logic [31:0]         i_hwdata,
   input  wire logic                i_hready,
   output wire logic [31:0]         o_hrdata,
   output wire logic                o_hreadyout,
   output wire logic                o_hresp,
   input  wire smi_pkg::smi_net_t   i_net,
   input  wire logic                i_int_fault,
   input  wire logic [DW-1:0]       i_pos_demand,
   input  wire logic [DW-1:0]       i_cal_demand,
   input  wire logic [CW-1:0]       i_cal_current,
   input  wire logic                i_cal_verify,
   input  wire logic                i_cal_done,
   output wire smi_pkg::smi_led_t   o_net_led,
   output wire smi_pkg::smi_led_t   o_mod_led,
   output wire smi_pkg::smi_mode_t  o_mode,
   output wire smi_pkg::smi_drv_t   o_drv_sel,
   output wire logic [CW-1:0]       o_fixed_cur,
   output wire logic [DW-1:0]       o_demand,
   output wire logic [15:0]         o_kp,
   output wire logic [15:0]         o_ki
);
   import smi_pkg::*;
   default clocking cb_sys @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
      return (a[31:8] == 24'h0) && (a[7:0] == off);
   endfunction
   smi_mode_t       mode_q;
   logic            cal_ok_q;
   smi_cfg_t        cfg_q;
   smi_cfg_t        edit_q;
   logic [15:0]     kp_q;
   logic [15:0]     ki_q;
   logic [DW-1:0]   man_q;
   smi_drv_t        drv_q;
   logic [CW-1:0]   fixed_q;
   logic [DW-1:0]   demand_q;
   smi_led_t        net_led_q;
   smi_led_t        mod_led_q;
   logic            wr_pend_q;
   logic [31:0]     wr_addr_q;
   logic [31:0]     rdata_q;
   logic            ready_q;
   logic            flash, acc;
   logic            st_svc_mode, st_fb_mode, st_svc_gain, st_fb_gain;
   logic            st_edit, st_load, st_man, req_vld;
   smi_mode_t       req_mode;
   logic [31:0]     status_w, rd_w;
   smi_blink #(
      .HALF_CYC (FLASH_HALF_CYC)
   ) u_blink (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .o_phase   (flash)
   );
   // Address phase of a word transfer
   assign acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == HSIZE_WORD);
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0;
         ready_q   <= 1'b0;
      end else begin
         wr_pend_q <= acc & i_hwrite;
         wr_addr_q <= i_haddr;
         ready_q   <= 1'b1;
      end
   end
   // Write strobe decode in the data phase
   always_comb begin
      st_svc_mode = 1'b0;
      st_fb_mode  = 1'b0;
      st_svc_gain = 1'b0;
      st_fb_gain  = 1'b0;
      st_edit     = 1'b0;
      st_load     = 1'b0;
      st_man      = 1'b0;
      if (!wr_pend_q) begin
         st_man = 1'b0;
      end else if (hit(wr_addr_q, OFF_SVC_MODE)) begin
         st_svc_mode = 1'b1;
      end else if (hit(wr_addr_q, OFF_FB_MODE)) begin
         st_fb_mode = 1'b1;
      end else if (hit(wr_addr_q, OFF_SVC_GAIN)) begin
         st_svc_gain = 1'b1;
      end else if (hit(wr_addr_q, OFF_FB_GAIN)) begin
         st_fb_gain = 1'b1;
      end else if (hit(wr_addr_q, OFF_CFG_EDIT)) begin
         st_edit = 1'b1;
      end else if (hit(wr_addr_q, OFF_CFG_LOAD)) begin
         st_load = i_hwdata[LOAD_BIT];
      end else if (hit(wr_addr_q, OFF_MAN_DEMAND)) begin
         st_man = 1'b1;
      end
   end
   // Mode requests: service link always, fieldbus only when enabled
   assign req_mode = smi_mode_t'(i_hwdata[2:0]);
   assign req_vld  = st_svc_mode | (st_fb_mode & cfg_q.fb_cal_en); // see RL20 see RL17
   function automatic logic legal(input smi_mode_t m, input logic vld, input logic cal);
      logic ok;
      ok = 1'b0;
      if (!vld) begin
         ok = 1'b0; // see RL19
      end else if (m == SMI_CALIB) begin
         ok = 1'b1;
      end else if (m == SMI_NEEDCAL) begin
         ok = ~cal;
      end else if ((m == SMI_IDLE) || (m == SMI_MANUAL) || (m == SMI_RUN)) begin
         ok = cal;
      end
      return ok;
   endfunction
   // Configuration staging and load
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         edit_q <= CFG_RST;
         cfg_q  <= CFG_RST;
      end else begin
         if (st_edit) begin
            edit_q <= smi_cfg_t'(i_hwdata[2:0]);
         end
         if (st_load) begin
            cfg_q <= edit_q; // see RL18
         end
      end
   end
   // Operating mode
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mode_q   <= SMI_UNCFG;
         cal_ok_q <= 1'b0;
      end else if (st_load) begin
         mode_q   <= edit_q.valid ? SMI_NEEDCAL : SMI_UNCFG; // see RL21 see RL19
         cal_ok_q <= 1'b0;
      end else if ((mode_q == SMI_CALIB) && i_cal_done) begin
         mode_q   <= SMI_CALD;
         cal_ok_q <= 1'b1;
      end else if (req_vld && legal(req_mode, cfg_q.valid, cal_ok_q)) begin
         mode_q   <= req_mode; // see RL20
      end
   end
   // Gains and manual demand
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         kp_q  <= GAIN_RST;
         ki_q  <= GAIN_RST;
         man_q <= '0;
      end else begin
         if (st_svc_gain || (st_fb_gain && cfg_q.fb_gain_en)) begin // see RL16
            kp_q <= i_hwdata[GAIN_KP_LSB +: 16];
            ki_q <= i_hwdata[GAIN_KI_LSB +: 16];
         end
         if (st_man) begin
            man_q <= i_hwdata[DW-1:0];
         end
      end
   end
   // Drive gating and demand source
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         drv_q    <= SMI_DRV_ZERO;
         fixed_q  <= '0;
         demand_q <= '0;
      end else begin
         case (mode_q)
            SMI_CALIB: begin
               if (i_cal_verify) begin
                  drv_q    <= SMI_DRV_LOOP; // see RL11 see RL12
                  fixed_q  <= '0;
                  demand_q <= i_cal_demand;
               end else begin
                  drv_q    <= SMI_DRV_FIXED; // see RL11
                  fixed_q  <= i_cal_current;
                  demand_q <= '0;
               end
            end
            SMI_MANUAL: begin
               drv_q    <= SMI_DRV_LOOP; // see RL13
               fixed_q  <= '0;
               demand_q <= man_q;
            end
            SMI_RUN: begin
               drv_q    <= SMI_DRV_LOOP; // see RL14
               fixed_q  <= '0;
               demand_q <= i_pos_demand;
            end
            default: begin
               drv_q    <= SMI_DRV_ZERO; // see RL8 see RL9 see RL10 see RL12
               fixed_q  <= '0;
               demand_q <= '0;
            end
         endcase
      end
   end
   // Network LED, worst condition first
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         net_led_q <= LED_OFF;
      end else if (i_net.fail) begin
         net_led_q <= LED_RED; // see RL4
      end else if (i_net.timeout) begin
         net_led_q <= flash ? LED_RED : LED_OFF; // see RL3 see RL22
      end else if (!i_net.online) begin
         net_led_q <= LED_OFF; // see RL1
      end else if (i_net.alloc) begin
         net_led_q <= LED_GREEN; // see RL2
      end else begin
         net_led_q <= flash ? LED_GREEN : LED_OFF; // see RL1 see RL22
      end
   end
   // Module LED
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mod_led_q <= LED_OFF;
      end else if (i_int_fault) begin
         mod_led_q <= LED_RED; // see RL7
      end else if (!cfg_q.valid || !cal_ok_q) begin
         mod_led_q <= flash ? LED_GREEN : LED_OFF; // see RL5
      end else begin
         mod_led_q <= LED_GREEN; // see RL6
      end
   end
   // Read data for the next data phase
   always_comb begin
      status_w = 32'h0;
      status_w[ST_MODE_LSB +: 3] = mode_q;
      status_w[ST_CAL_BIT]       = cal_ok_q;
      status_w[ST_NET_LSB +: 2]  = net_led_q;
      status_w[ST_MOD_LSB +: 2]  = mod_led_q;
      status_w[ST_CFG_LSB +: 3]  = cfg_q;
      status_w[ST_DRV_LSB +: 2]  = drv_q;
      rd_w = 32'h0;
      if (hit(i_haddr, OFF_SVC_GAIN) || hit(i_haddr, OFF_FB_GAIN)) begin
         rd_w[GAIN_KP_LSB +: 16] = kp_q;
         rd_w[GAIN_KI_LSB +: 16] = ki_q;
      end else if (hit(i_haddr, OFF_CFG_EDIT)) begin
         rd_w[2:0] = edit_q;
      end else if (hit(i_haddr, OFF_MAN_DEMAND)) begin
         rd_w[DW-1:0] = man_q;
      end else if (hit(i_haddr, OFF_STATUS)) begin
         rd_w = status_w; // see RL15
      end else if (hit(i_haddr, OFF_DEMAND)) begin
         rd_w[DW-1:0] = demand_q; // see RL15
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdata_q <= 32'h0;
      end else if (acc && !i_hwrite) begin
         rdata_q <= rd_w;
      end
   end
   assign o_hrdata    = rdata_q;
   assign o_hreadyout = ready_q;
   assign o_hresp     = HRESP_OKAY;
   assign o_net_led   = net_led_q;
   assign o_mod_led   = mod_led_q;
   assign o_mode      = mode_q;
   assign o_drv_sel   = drv_q;
   assign o_fixed_cur = fixed_q;
   assign o_demand    = demand_q;
   assign o_kp        = kp_q;
   assign o_ki        = ki_q;
   property p_net_flash_green;
      (i_net == 4'b0001) |=> (!o_net_led.red && o_net_led.green == $past(flash));
   endproperty
   a_net_flash_green: assert property (p_net_flash_green) // see RL1
      else $error("Network LED not flashing green while online");
   property p_net_green;
      (i_net == 4'b0011) ##1 (i_net == 4'b0011) |=> (o_net_led == LED_GREEN) [*1];
   endproperty
   a_net_green: assert property (p_net_green) // see RL2
      else $error("Network LED not steady green when allocated");
   property p_net_flash_red;
      (i_net.timeout && !i_net.fail) |=> (!o_net_led.green && o_net_led.red == $past(flash));
   endproperty
   a_net_flash_red: assert property (p_net_flash_red) // see RL3
      else $error("Network LED not flashing red on timeout");
   property p_net_red;
      i_net.fail |=> (o_net_led == LED_RED);
   endproperty
   a_net_red: assert property (p_net_red) // see RL4
      else $error("Network LED not red on communication failure");
   property p_mod_red;
      i_int_fault |=> (o_mod_led == LED_RED);
   endproperty
   a_mod_red: assert property (p_mod_red) // see RL7
      else $error("Module LED not red on internal fault");
   property p_mod_flash;
      (!i_int_fault && !cal_ok_q) |=> (!o_mod_led.red && o_mod_led.green == $past(flash));
   endproperty
   a_mod_flash: assert property (p_mod_flash) // see RL5
      else $error("Module LED not flashing green while uncalibrated");
   property p_zero_drive;
      (mode_q inside {SMI_UNCFG, SMI_NEEDCAL, SMI_IDLE, SMI_CALD})
      |=> (o_drv_sel == SMI_DRV_ZERO && o_fixed_cur == '0 && o_demand == '0);
   endproperty
   a_zero_drive: assert property (p_zero_drive) // see RL8 see RL9 see RL10
      else $error("Drive not held at zero in an inactive mode");
   property p_run_demand;
      (mode_q == SMI_RUN) |=> (o_drv_sel == SMI_DRV_LOOP && o_demand == $past(i_pos_demand));
   endproperty
   a_run_demand: assert property (p_run_demand) // see RL14
      else $error("Running mode not following normal demand");
   property p_man_demand;
      (mode_q == SMI_MANUAL) |=> (o_drv_sel == SMI_DRV_LOOP && o_demand == $past(man_q));
   endproperty
   a_man_demand: assert property (p_man_demand) // see RL13
      else $error("Manual mode not following user demand");
   property p_fb_gain_lock;
      (st_fb_gain && !cfg_q.fb_gain_en) |=> $stable(o_kp) && $stable(o_ki);
   endproperty
   a_fb_gain_lock: assert property (p_fb_gain_lock) // see RL16
      else $error("Fieldbus gain write taken while disabled");
   property p_fb_mode_lock;
      (st_fb_mode && !cfg_q.fb_cal_en && !(mode_q == SMI_CALIB && i_cal_done))
      |=> $stable(mode_q);
   endproperty
   a_fb_mode_lock: assert property (p_fb_mode_lock) // see RL20
      else $error("Fieldbus mode request taken while disabled");
   property p_load_stops;
      st_load |=> (mode_q inside {SMI_UNCFG, SMI_NEEDCAL}) ##1 (o_drv_sel == SMI_DRV_ZERO);
   endproperty
   a_load_stops: assert property (p_load_stops) // see RL21
      else $error("Configuration load did not shut the drive down");
endmodule

// ### smi_pkg.sv
// Package for the servo mode and status indicator block
// Assumes a 100 MHz system clock and an AHB-Lite register bus
package smi_pkg;

   // Clock and LED flash timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned FLASH_HALF_NS  = 500_000_000;
   localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFF_SVC_MODE   = 8'h00;
   localparam logic [7:0] OFF_FB_MODE    = 8'h04;
   localparam logic [7:0] OFF_SVC_GAIN   = 8'h08;
   localparam logic [7:0] OFF_FB_GAIN    = 8'h0c;
   localparam logic [7:0] OFF_CFG_EDIT   = 8'h10;
   localparam logic [7:0] OFF_CFG_LOAD   = 8'h14;
   localparam logic [7:0] OFF_MAN_DEMAND = 8'h18;
   localparam logic [7:0] OFF_STATUS     = 8'h1c;
   localparam logic [7:0] OFF_DEMAND     = 8'h20;

   // Field positions
   localparam int unsigned GAIN_KP_LSB = 0;
   localparam int unsigned GAIN_KI_LSB = 16;
   localparam int unsigned LOAD_BIT    = 0;
   localparam int unsigned ST_MODE_LSB = 0;
   localparam int unsigned ST_CAL_BIT  = 3;
   localparam int unsigned ST_NET_LSB  = 4;
   localparam int unsigned ST_MOD_LSB  = 6;
   localparam int unsigned ST_CFG_LSB  = 8;
   localparam int unsigned ST_DRV_LSB  = 12;

   // Bus constants
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;

   typedef enum logic [2:0] {
      SMI_UNCFG   = 3'b000,
      SMI_NEEDCAL = 3'b001,
      SMI_IDLE    = 3'b010,
      SMI_CALIB   = 3'b011,
      SMI_CALD    = 3'b100,
      SMI_MANUAL  = 3'b101,
      SMI_RUN     = 3'b110
   } smi_mode_t;

   typedef enum logic [1:0] {
      SMI_DRV_ZERO  = 2'b00,
      SMI_DRV_FIXED = 2'b01,
      SMI_DRV_LOOP  = 2'b10
   } smi_drv_t;

   typedef struct packed {
      logic red;
      logic green;
   } smi_led_t;

   typedef struct packed {
      logic fail;
      logic timeout;
      logic alloc;
      logic online;
   } smi_net_t;

   typedef struct packed {
      logic fb_cal_en;
      logic fb_gain_en;
      logic valid;
   } smi_cfg_t;

   // LED encodings and reset values
   localparam smi_led_t LED_OFF   = 2'h0;
   localparam smi_led_t LED_GREEN = 2'h1;
   localparam smi_led_t LED_RED   = 2'h2;
   localparam smi_cfg_t CFG_RST   = 3'h0;
   localparam logic [15:0] GAIN_RST = 16'h0;

endpackage

// ### smi_blink.sv
// Flash phase generator for the status LEDs
// Assumes one free running system clock with synchronous reset
`timescale 1ns/1ns
module smi_blink #(
   parameter int unsigned HALF_CYC = smi_pkg::FLASH_HALF_CYC
)(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   output wire logic o_phase
);
   import smi_pkg::*;
   localparam int unsigned CNTW = $clog2(HALF_CYC + 1);
   localparam logic [CNTW-1:0] CNT_LAST = CNTW'(HALF_CYC - 1);

   logic [CNTW-1:0] cnt_q;
   logic            phase_q;

   // Toggle every half period
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_q   <= '0;
         phase_q <= 1'b0;
      end else if (cnt_q == CNT_LAST) begin
         cnt_q   <= '0;
         phase_q <= ~phase_q;
      end else begin
         cnt_q   <= cnt_q + 1'b1;
      end
   end

   assign o_phase = phase_q;
endmodule

// ### smi_host.sv
// Register bus master standing in for the service link and the fieldbus master
// Assumes one slave whose hreadyout is fed back as i_hready
`timescale 1ns/1ns
module smi_host (
   input  wire logic        i_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   output logic             o_hsel,
   output logic [31:0]      o_haddr,
   output logic [1:0]       o_htrans,
   output logic             o_hwrite,
   output logic [2:0]       o_hsize,
   output logic [31:0]      o_hwdata,
   output logic             o_tmo
);
   import smi_pkg::*;

   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = HSIZE_WORD;
      o_hwdata = 32'h0;
      o_tmo = 1'b0;
   end

   // Waits for hready, returns at the edge that samples it high
   task automatic wait_rdy(output logic [31:0] rd);
      int n;
      n = 0;
      @(negedge i_clk);
      while (i_hready !== 1'b1 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      if (n == 50) o_tmo <= 1'b1;
      rd = i_hrdata;
      @(posedge i_clk);
   endtask

   // One register read or write: address phase, then data phase with the write data
   task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
      logic [31:0] x;
      @(posedge i_clk);
      o_hsel <= 1'b1;
      o_htrans <= 2'h2;
      o_haddr <= a;
      o_hwrite <= wr;
      o_hsize <= HSIZE_WORD;
      wait_rdy(x);
      o_htrans <= 2'h0;
      o_hwdata <= wd;
      wait_rdy(rd);
   endtask
endmodule

// ### smi_top_bench.sv
// Self-checking bench for the mode tracking and status LED block
// Assumes the host model as the only bus master, flash half period of 4
`timescale 1ns/1ns
module smi_top_bench;
   import smi_pkg::*;

   logic        i_clk, i_sys_rst, hsel, hwrite, hready, hresp, tmo;
   logic        i_int_fault, i_cal_verify, i_cal_done;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] pos_dem, cal_dem, cal_cur, fixed_cur, demand, kp, ki;
   smi_net_t    i_net;
   smi_led_t    net_led, mod_led;
   smi_mode_t   mode;
   smi_drv_t    drv;
   int          num_errors, checked;

   smi_host host (.i_clk(i_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
      .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
      .o_hwdata(hwdata), .o_tmo(tmo));

   smi_top #(.FLASH_HALF_CYC(4)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_net(i_net), .i_int_fault(i_int_fault), .i_pos_demand(pos_dem),
      .i_cal_demand(cal_dem), .i_cal_current(cal_cur), .i_cal_verify(i_cal_verify),
      .i_cal_done(i_cal_done), .o_net_led(net_led), .o_mod_led(mod_led), .o_mode(mode),
      .o_drv_sel(drv), .o_fixed_cur(fixed_cur), .o_demand(demand), .o_kp(kp), .o_ki(ki));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic summarize();
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge tmo) begin
      num_errors++;
      summarize();
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      host.xfer(a, 1'b1, d, x);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      host.xfer(a, 1'b0, 32'h0, d);
   endtask

   // Lets n edges pass, then stops where outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   // Counts cycles of the chosen LED at the given colour over eight cycles
   task automatic led_cnt(input bit net, input smi_led_t on, output int n);
      smi_led_t v;
      n = 0;
      repeat (8) begin
         @(negedge i_clk);
         v = net ? net_led : mod_led;
         if (v === on) n++;
         else if (v !== LED_OFF) n += 100;
      end
   endtask

   task automatic t_reset();
      logic [31:0] d;
      chk(mode, SMI_UNCFG);
      chk(drv, SMI_DRV_ZERO);
      wr(OFF_SVC_MODE, 32'h3);
      settle(3);
      chk(mode, SMI_UNCFG);
      chk(drv, SMI_DRV_ZERO);
      rd(32'h0000_0140, d);
      chk(d, 32'h0);
      chk(hresp, HRESP_OKAY);
   endtask

   task automatic t_config();
      logic [31:0] d;
      int n;
      wr(OFF_CFG_EDIT, 32'h1);
      rd(OFF_CFG_EDIT, d);
      chk(d, 32'h1);
      rd(OFF_STATUS, d);
      chk(d[10:8], 3'h0);
      chk(mode, SMI_UNCFG);
      wr(OFF_CFG_LOAD, 32'h1);
      settle(3);
      chk(mode, SMI_NEEDCAL);
      chk(drv, SMI_DRV_ZERO);
      rd(OFF_STATUS, d);
      chk(d[10:8], 3'h1);
      led_cnt(1'b0, LED_GREEN, n);
      chk(n, 4);
   endtask

   task automatic t_gain();
      logic [31:0] d;
      wr(OFF_SVC_GAIN, 32'h0002_0001);
      wr(OFF_FB_GAIN, 32'h0009_0008);
      settle(3);
      chk(kp, 16'h1);
      chk(ki, 16'h2);
      rd(OFF_FB_GAIN, d);
      chk(d, 32'h0002_0001);
      rd(32'h0000_0108, d);
      chk(d, 32'h0);
      wr(OFF_FB_MODE, 32'h3);
      settle(3);
      chk(mode, SMI_NEEDCAL);
   endtask

   task automatic t_calib();
      wr(OFF_SVC_MODE, 32'h3);
      settle(3);
      chk(mode, SMI_CALIB);
      chk(drv, SMI_DRV_FIXED);
      chk(fixed_cur, 16'h0055);
      @(posedge i_clk);
      i_cal_verify <= 1'b1;
      settle(3);
      chk(drv, SMI_DRV_LOOP);
      chk(demand, 16'h2222);
      @(posedge i_clk);
      i_cal_done <= 1'b1;
      @(posedge i_clk);
      i_cal_done <= 1'b0;
      i_cal_verify <= 1'b0;
      settle(3);
      chk(mode, SMI_CALD);
      chk(drv, SMI_DRV_ZERO);
   endtask

   task automatic t_modes();
      logic [31:0] d;
      int n;
      wr(OFF_MAN_DEMAND, 32'h1234);
      wr(OFF_SVC_MODE, 32'h5);
      settle(3);
      chk(drv, SMI_DRV_LOOP);
      chk(demand, 16'h1234);
      wr(OFF_SVC_MODE, 32'h2);
      settle(3);
      chk(mode, SMI_IDLE);
      chk(drv, SMI_DRV_ZERO);
      wr(OFF_SVC_MODE, 32'h1);
      settle(3);
      chk(mode, SMI_IDLE);
      wr(OFF_SVC_MODE, 32'h6);
      settle(3);
      chk(drv, SMI_DRV_LOOP);
      chk(demand, 16'h1111);
      @(posedge i_clk);
      pos_dem <= 16'h4321;
      settle(2);
      chk(demand, 16'h4321);
      rd(OFF_DEMAND, d);
      chk(d, 32'h0000_4321);
      rd(OFF_STATUS, d);
      chk(d[2:0], SMI_RUN);
      chk(d[13:12], SMI_DRV_LOOP);
      led_cnt(1'b0, LED_GREEN, n);
      chk(n, 8);
      @(posedge i_clk);
      i_int_fault <= 1'b1;
      settle(2);
      led_cnt(1'b0, LED_RED, n);
      chk(n, 8);
      @(posedge i_clk);
      i_int_fault <= 1'b0;
   endtask

   task automatic t_net();
      smi_net_t nv[5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h9};
      smi_led_t ec[5] = '{LED_GREEN, LED_GREEN, LED_GREEN, LED_RED, LED_RED};
      int en[5] = '{0, 4, 8, 4, 8};
      int n;
      for (int i = 0; i < 5; i++) begin
         @(posedge i_clk);
         i_net <= nv[i];
         settle(2);
         led_cnt(1'b1, ec[i], n);
         chk(n, en[i]);
      end
   endtask

   task automatic t_reload();
      wr(OFF_CFG_EDIT, 32'h7);
      wr(OFF_CFG_LOAD, 32'h1);
      settle(3);
      chk(mode, SMI_NEEDCAL);
      chk(drv, SMI_DRV_ZERO);
      wr(OFF_SVC_MODE, 32'h6);
      settle(3);
      chk(mode, SMI_NEEDCAL);
      chk(drv, SMI_DRV_ZERO);
      wr(OFF_FB_GAIN, 32'h0009_0008);
      settle(3);
      chk(kp, 16'h8);
      wr(OFF_FB_MODE, 32'h3);
      settle(3);
      chk(mode, SMI_CALIB);
   endtask

   initial begin
      num_errors = 0;
      checked = 0;
      i_sys_rst = 1'b1;
      i_net = 4'h0;
      i_int_fault = 1'b0;
      i_cal_verify = 1'b0;
      i_cal_done = 1'b0;
      pos_dem = 16'h1111;
      cal_dem = 16'h2222;
      cal_cur = 16'h0055;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      settle(2);
      t_reset();
      t_config();
      t_gain();
      t_calib();
      t_modes();
      t_net();
      t_reload();
      summarize();
   end
endmodule
